// ### rtl/core_seq_pkg.sv
package core_seq_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int WORD_W = 36;
   localparam int HALF_W = 18;
   localparam int ADDR_W = 14;
   localparam int UNIT_W = 3;
   // Times in ns, from t0 except the write release, write portion and phase durations
   localparam int T_DATA_ON_NS = 350;
   localparam int T_DATA_OFF_NS = 800;
   localparam int T_READ_DONE_ON_NS = 450;
   localparam int T_READ_DONE_OFF_NS = 500;
   localparam int T_BUSY_ON_NS = 90;
   localparam int T_BUSY_OFF_NS = 800;
   localparam int T_CYCLE_DONE_ON_NS = 800;
   localparam int T_CYCLE_DONE_OFF_NS = 880;
   localparam int T_WRITE_RELEASE_NS = 30;
   localparam int T_WRITE_PORTION_NS = 450;
   localparam int T_PHASE_NS = 30;
   localparam int T_LATE_DATA_NS = 200;
   localparam int T_EARLY_DATA_NS = 150;
   // Cycle counts; onsets rounded up, ends rounded down
   localparam int C_DATA_ON = (T_DATA_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_DATA_OFF = T_DATA_OFF_NS / CLK_PERIOD_NS;
   localparam int C_RD_ON = (T_READ_DONE_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_RD_OFF = T_READ_DONE_OFF_NS / CLK_PERIOD_NS;
   localparam int C_BUSY_ON = (T_BUSY_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_BUSY_OFF = T_BUSY_OFF_NS / CLK_PERIOD_NS;
   localparam int C_CD_ON = (T_CYCLE_DONE_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_CD_OFF = T_CYCLE_DONE_OFF_NS / CLK_PERIOD_NS;
   localparam int C_REL = T_WRITE_RELEASE_NS / CLK_PERIOD_NS;
   localparam int C_WRITE = T_WRITE_PORTION_NS / CLK_PERIOD_NS;
   localparam int C_PHASE = T_PHASE_NS / CLK_PERIOD_NS;
   localparam int C_LATE_DATA = (T_LATE_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_EARLY_DATA = T_EARLY_DATA_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_SELECT = 3'b001,
      ST_READ = 3'b011,
      ST_WAIT_WR = 3'b010,
      ST_WRITE = 3'b110,
      ST_TAIL = 3'b111
   } seq_state_t;
endpackage

// ### rtl/core_memory_cycle_sequencer.sv
module core_memory_cycle_sequencer
   import core_seq_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cycle_start_in_n,
   input wire logic write_phase_start_n,
   input wire logic split_mode_n,
   input wire logic full_word_write,
   input wire logic [3:0] byte_write_n,
   input wire logic byte_strobe_timing_sel_n,
   input wire logic late_write_data_sel_n,
   input wire logic capacity_sel_n,
   input wire logic output_clear_in_n,
   input wire logic retain_guard,
   input wire logic power_clear_n,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic extra_addr_bit,
   input wire logic [UNIT_W-1:0] unit_addr_lines,
   input wire logic [UNIT_W-1:0] unit_switch,
   input wire logic [WORD_W-1:0] write_data_in,
   input wire logic [WORD_W-1:0] stored_word,
   output logic [WORD_W-1:0] read_word_lines,
   output logic read_word_oe,
   output logic cycle_done_strobe_n,
   output logic read_done_strobe_n,
   output logic cycle_active_flag_n,
   output logic [ADDR_W:0] latched_addr,
   output logic [WORD_W-1:0] core_write_word,
   output logic [3:0] core_write_en,
   output logic osc_phase
);
   import core_seq_pkg::*;

   localparam int SYNC_W = 11;

   ////////////////////////////////////////////////////////////////////
   // Two-stage input synchronisers
   logic [SYNC_W-1:0] async_in;
   logic [SYNC_W-1:0] meta_q;
   logic [SYNC_W-1:0] sync_q;
   assign async_in = {cycle_start_in_n, write_phase_start_n, split_mode_n,
                      full_word_write, byte_strobe_timing_sel_n, late_write_data_sel_n,
                      capacity_sel_n, output_clear_in_n, retain_guard, power_clear_n,
                      extra_addr_bit};
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta_q <= '1;
         sync_q <= '1;
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
   logic ci_n, wi_n, split_n, ww, bct_n, ldt_n, cap_n, clr_n, guard, pwr_n, a17;
   assign {ci_n, wi_n, split_n, ww, bct_n, ldt_n, cap_n, clr_n, guard, pwr_n, a17} = sync_q;

   logic [3:0] byte_meta_q, byte_sync_q;
   logic [ADDR_W-1:0] addr_meta_q, addr_sync_q;
   logic [UNIT_W-1:0] unit_meta_q, unit_sync_q;
   logic [WORD_W-1:0] din_meta_q, din_sync_q;
   always_ff @(posedge clk)
   begin
      byte_meta_q <= byte_write_n;
      byte_sync_q <= byte_meta_q;
      addr_meta_q <= addr_in;
      addr_sync_q <= addr_meta_q;
      unit_meta_q <= unit_addr_lines;
      unit_sync_q <= unit_meta_q;
      din_meta_q <= write_data_in;
      din_sync_q <= din_meta_q;
   end

   ////////////////////////////////////////////////////////////////////
   // Unit match; capacity strap moves the field up one bit
   function automatic logic unit_hit(input logic cap_low, input logic [ADDR_W-1:0] a,
                                     input logic [UNIT_W-1:0] u, input logic hi,
                                     input logic [UNIT_W-1:0] sw);
      logic [UNIT_W-1:0] field;
      field = cap_low ? {hi, u[UNIT_W-1:1]} : u;
      unit_hit = (field == sw);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed
   {
      seq_state_t st;
      logic ci_prev;
      logic [CNT_W-1:0] t;
      logic [CNT_W-1:0] w;
      logic [1:0] ph;
      logic osc;
      logic hold;
      logic [ADDR_W:0] addr;
      logic [3:0] bytes;
      logic word_wr;
      logic split;
      logic [WORD_W-1:0] dout;
      logic oe;
      logic rel_pend;
      logic [CNT_W-1:0] rel_cnt;
      logic rd_n;
      logic cd_n;
      logic busy_n;
      logic [WORD_W-1:0] wdata;
      logic [WORD_W-1:0] din;
      logic [3:0] wen;
   } seq_t;

   seq_t s_q, s_d;
   logic ci_fall;
   logic [ADDR_W:0] live_addr;
   assign ci_fall = s_q.ci_prev && !ci_n;
   assign live_addr = cap_n ? {1'b0, addr_sync_q} : {a17, addr_sync_q};

   always_comb
   begin
      s_d = s_q;
      s_d.ci_prev = ci_n;
      if (!s_q.hold)
      begin
         s_d.addr = live_addr;
      end
      if (s_q.st != ST_IDLE && s_q.st != ST_WAIT_WR)
      begin
         // Gated oscillator: 30 ns phases only outside idle and the split write wait
         if (s_q.ph == 2'(C_PHASE - 1))
         begin
            s_d.ph = '0;
            s_d.osc = !s_q.osc;
         end
         else
         begin
            s_d.ph = s_q.ph + 2'd1;
         end
      end
      else
      begin
         s_d.ph = '0;
         s_d.osc = 1'b0;
      end
      if (s_q.st != ST_IDLE && s_q.t != '1)
      begin
         s_d.t = s_q.t + CNT_W'(1);
      end
      case (s_q.st)
         ST_IDLE:
         begin
            s_d.t = '0;
            s_d.hold = 1'b0;
            s_d.wen = '0;
            if (ci_fall && pwr_n && guard)
            begin
               s_d.st = ST_SELECT;
               s_d.t = CNT_W'(1);
               s_d.split = !split_n;
               s_d.word_wr = ww;
               s_d.bytes = byte_sync_q;
               s_d.hold = 1'b1;
            end
         end
         ST_SELECT:
         begin
            s_d.st = unit_hit(!cap_n, addr_sync_q, unit_sync_q, a17, unit_switch)
                     ? ST_READ : ST_IDLE;
         end
         ST_READ:
         begin
            if (s_q.t == (ldt_n ? CNT_W'(C_EARLY_DATA / 2)
                          : CNT_W'((C_LATE_DATA + C_DATA_ON) / 2)))
            begin
               s_d.din = din_sync_q;
            end
            if (s_q.t == CNT_W'(C_RD_ON - 1))
            begin
               if (s_q.split)
               begin
                  s_d.st = ST_WAIT_WR;
               end
               else
               begin
                  s_d.st = ST_WRITE;
                  s_d.w = '0;
               end
            end
         end
         ST_WAIT_WR:
         begin
            if (!wi_n)
            begin
               s_d.st = ST_WRITE;
               s_d.w = '0;
               s_d.rel_pend = 1'b1;
               s_d.rel_cnt = '0;
               if (bct_n)
               begin
                  s_d.bytes = byte_sync_q;
               end
            end
         end
         ST_WRITE:
         begin
            s_d.w = s_q.w + CNT_W'(1);
            if (s_q.w == '0)
            begin
               // Split takes data at write start, full from strap window
               s_d.wdata = stored_word;
               for (int b = 0; b < 4; b++)
               begin
                  if (!s_q.bytes[b] || !s_q.word_wr)
                  begin
                     s_d.wdata[b*9 +: 9] = s_q.split ? din_sync_q[b*9 +: 9] : s_q.din[b*9 +: 9];
                  end
               end
               s_d.wen = 4'hf;
            end
            if (s_q.w == CNT_W'(C_WRITE - 1))
            begin
               s_d.st = ST_TAIL;
               s_d.wen = '0;
            end
         end
         ST_TAIL:
         begin
            if (s_q.cd_n && s_q.busy_n)
            begin
               s_d.st = ST_IDLE;
               s_d.hold = 1'b0;
            end
         end
         default:
         begin
            s_d.st = ST_IDLE;
         end
      endcase
      // Status strobes from t0-relative count
      s_d.busy_n = !(s_q.st != ST_IDLE && s_q.t >= CNT_W'(C_BUSY_ON - 1)
                     && (s_q.split || s_q.t < CNT_W'(C_BUSY_OFF - 1)));
      if (s_q.split && s_q.st == ST_TAIL)
      begin
         s_d.busy_n = 1'b1;
      end
      s_d.rd_n = !(s_q.st != ST_IDLE && s_q.t >= CNT_W'(C_RD_ON - 1)
                   && s_q.t < CNT_W'(C_RD_OFF - 1));
      s_d.cd_n = !(s_q.st != ST_IDLE && !s_q.split && s_q.t >= CNT_W'(C_CD_ON - 1)
                   && s_q.t < CNT_W'(C_CD_OFF - 1));
      // Read word drive window
      if (s_q.st != ST_IDLE && s_q.t == CNT_W'(C_DATA_ON - 1) && s_q.word_wr)
      begin
         s_d.dout = stored_word;
         s_d.oe = 1'b1;
      end
      if (!s_q.split && s_q.t == CNT_W'(C_DATA_OFF - 1))
      begin
         s_d.oe = 1'b0;
      end
      if (s_q.rel_pend)
      begin
         s_d.rel_cnt = s_q.rel_cnt + CNT_W'(1);
         if (s_q.rel_cnt == CNT_W'(C_REL - 1))
         begin
            s_d.oe = 1'b0;
            s_d.rel_pend = 1'b0;
         end
      end
      if (!clr_n || s_q.st == ST_IDLE)
      begin
         s_d.oe = 1'b0;
      end
      if (!s_d.oe)
      begin
         s_d.dout = '0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s_q <= '{st: ST_IDLE, ci_prev: 1'b1, rd_n: 1'b1, cd_n: 1'b1, busy_n: 1'b1,
                  default: '0};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign read_word_lines = s_q.dout;
   assign read_word_oe = s_q.oe;
   assign cycle_done_strobe_n = s_q.cd_n;
   assign read_done_strobe_n = s_q.rd_n;
   assign cycle_active_flag_n = s_q.busy_n;
   assign latched_addr = s_q.addr;
   assign core_write_word = s_q.wdata;
   assign core_write_en = s_q.wen;
   assign osc_phase = s_q.osc;

   ////////////////////////////////////////////////////////////////////
   // Checks
   a_busy_hold: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(cycle_active_flag_n) && !s_q.split |-> !cycle_active_flag_n [*8])
      else $error("busy dropped early");
   a_read_done_len: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(read_done_strobe_n) |-> !read_done_strobe_n [*5] ##1 read_done_strobe_n)
      else $error("read done width wrong");
   a_cycle_done_len: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(cycle_done_strobe_n) |-> !cycle_done_strobe_n [*8] ##1 cycle_done_strobe_n)
      else $error("cycle done width wrong");
   a_clear_forces: assert property (@(posedge clk) disable iff (!rst_n)
      !clr_n |=> !read_word_oe)
      else $error("clear did not release data");
   a_no_start_pwr: assert property (@(posedge clk) disable iff (!rst_n)
      s_q.st == ST_IDLE && (!pwr_n || !guard) |=> s_q.st == ST_IDLE)
      else $error("cycle started while blocked");
   a_hold_latch: assert property (@(posedge clk) disable iff (!rst_n)
      s_q.hold && $past(s_q.hold) |-> $stable(latched_addr))
      else $error("address moved while held");
   a_split_waits: assert property (@(posedge clk) disable iff (!rst_n)
      s_q.st == ST_WAIT_WR && wi_n |=> s_q.st == ST_WAIT_WR)
      else $error("write started without request");
   a_full_auto: assert property (@(posedge clk) disable iff (!rst_n)
      s_q.st == ST_READ && !s_q.split |-> ##[1:60] s_q.st == ST_WRITE)
      else $error("write portion did not follow");
   a_release: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(s_q.rel_pend) |-> ##[1:4] !read_word_oe)
      else $error("read word not released");
   a_osc_gate: assert property (@(posedge clk) disable iff (!rst_n)
      s_q.st == ST_IDLE |=> !osc_phase)
      else $error("oscillator ran while idle");
   c_full: cover property (@(posedge clk) disable iff (!rst_n)
      $fell(cycle_done_strobe_n));
   c_split: cover property (@(posedge clk) disable iff (!rst_n)
      s_q.st == ST_WAIT_WR ##1 s_q.st == ST_WRITE);
   c_clear: cover property (@(posedge clk) disable iff (!rst_n)
      read_word_oe ##1 !clr_n);
endmodule

// ### dv/host_model.sv
module host_model
   import core_seq_pkg::*;
(
   input wire logic clk,
   input wire logic go,
   input wire logic split,
   input wire logic late,
   input wire logic [WORD_W-1:0] wdata,
   output logic cyc_n,
   output logic wr_n,
   output logic [3:0] bw_n,
   output logic [WORD_W-1:0] dout
);
   timeunit 1ns;
   timeprecision 1ps;
   int t = 0;
   int j;
   logic run = 1'b0;
   logic keep;
   initial
   begin
      cyc_n = 1'b1;
      wr_n = 1'b1;
      bw_n = 4'hf;
      dout = '0;
   end
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
   begin
      j = run ? t + 1 : 0;
      keep = (go || run) && (split ? (j >= 50 && j <= 64) : late ? j <= 14 : (j >= 20 && j <= 34));
      dout <= keep ? wdata : ~dout;
      if (go && !run)
      begin
         run <= 1'b1;
         t <= 0;
         cyc_n <= 1'b0;
      end
      else if (run)
      begin
         t <= t + 1;
         if (t == 9) cyc_n <= 1'b1;
         if (split && t == 49) wr_n <= 1'b0;
         if (t == 64) wr_n <= 1'b1;
         if (t == 70) run <= 1'b0;
      end
   end
endmodule

// ### dv/core_memory_cycle_sequencer_tb.sv
module core_memory_cycle_sequencer_tb
   import core_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [35:0] f [11]; logic [10:0] m;} note_t;
   logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, split = 1'b0, late = 1'b1, er = 1'b0;
   logic ww = 1'b1, pwr_n = 1'b1, guard = 1'b1;
   logic [UNIT_W-1:0] unit_a = 3'h2, unit_s = 3'h2;
   logic [ADDR_W-1:0] addr = '0;
   logic [WORD_W-1:0] stored = '0, wdata = '0, rw, cw, hd;
   logic [ADDR_W:0] la;
   logic [3:0] cen, bw_n;
   logic oe, cd_n, rd_n, busy_n, ph, cyc_n, wr_n, pb = 1, prd = 1, pcd = 1, poe = 0;
   wire logic clr_n;
   int seed = 32'h4b1e;
   int failures = 0, comparisons = 0, starts = 0, results = 0, cyc = 0, tb0 = 0, post = 0;
   int tcnt = 0;
   logic [35:0] r [11];
   note_t q[$];
   note_t e;
   string nm [11] = '{"busy", "rd_off", "rd_len", "cd_off", "cd_len", "oe_off", "oe_len",
      "data", "addr", "wword", "wen"};
   logic [3:0] modes [7] = '{4'b0110, 4'b0010, 4'b0000, 4'b0111, 4'b1110, 4'b1010, 4'b1111};
   assign clr_n = er ? rd_n : 1'b1;
   initial
   begin
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   host_model u_host_model (.clk(clk), .go(go), .split(split), .late(late), .wdata(wdata),
      .cyc_n(cyc_n), .wr_n(wr_n), .bw_n(bw_n), .dout(hd));
   core_memory_cycle_sequencer u_core_memory_cycle_sequencer (.clk(clk), .rst_n(rst_n),
      .cycle_start_in_n(cyc_n), .write_phase_start_n(wr_n), .split_mode_n(~split),
      .full_word_write(ww), .byte_write_n(bw_n), .byte_strobe_timing_sel_n(late),
      .late_write_data_sel_n(late), .capacity_sel_n(1'b1), .output_clear_in_n(clr_n),
      .retain_guard(guard), .power_clear_n(pwr_n), .addr_in(addr), .extra_addr_bit(1'b0),
      .unit_addr_lines(unit_a), .unit_switch(unit_s), .write_data_in(hd),
      .stored_word(stored), .read_word_lines(rw), .read_word_oe(oe),
      .cycle_done_strobe_n(cd_n), .read_done_strobe_n(rd_n), .cycle_active_flag_n(busy_n),
      .latched_addr(la), .core_write_word(cw), .core_write_en(cen), .osc_phase(ph));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(string n, logic [35:0] s, logic [35:0] x);
      comparisons++;
      if (s !== x)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
      begin
         $display("ALL TESTS PASSED");
      end
      else
      begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic run_cyc(logic s, logic w, logic l, logic x);
      note_t n;
      logic [13:0] a;
      logic [35:0] d, dw;
      int n0;
      a = 14'($random(seed));
      d = 36'({$random(seed), $random(seed)});
      dw = 36'({$random(seed), $random(seed)});
      n0 = results;
      n.f = '{default: '0};
      n.m = 11'h7ff;
      if (s) n.m[3] = 1'b0;
      if (w) n.m[10:9] = 2'b00;
      else n.m[5] = 1'b0;
      // Split: state hand-over into write plus busy release step add two cycles
      n.f[0] = s ? 36'(50 + C_WRITE + 2 - C_BUSY_ON) : 36'(C_BUSY_OFF - C_BUSY_ON);
      n.f[1] = 36'(C_RD_ON - C_BUSY_ON);
      n.f[2] = 36'(C_RD_OFF - C_RD_ON);
      n.f[3] = 36'(C_CD_ON - C_BUSY_ON);
      n.f[4] = s ? 36'h0 : 36'(C_CD_OFF - C_CD_ON);
      n.f[5] = 36'(C_DATA_ON - C_BUSY_ON);
      // Clear input passes two sync flops; write start one more state step
      n.f[6] = !w ? 36'h0 : x ? 36'(C_RD_ON - C_DATA_ON + 3) :
         s ? 36'(50 + C_REL + 1 - C_DATA_ON) : 36'(C_DATA_OFF - C_DATA_ON);
      n.f[7] = w ? d : 36'h0;
      n.f[8] = 36'({1'b0, a});
      n.f[9] = dw;
      n.f[10] = 36'hf;
      q.push_back(n);
      @(posedge clk);
      split <= s;
      ww <= w;
      late <= l;
      er <= x;
      addr <= a;
      stored <= d;
      wdata <= dw;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (20) @(posedge clk);
      addr <= ~a;
      while (results == n0) @(posedge clk);
   endtask
   task automatic refuse(int k);
      int s0;
      s0 = starts;
      @(posedge clk);
      unit_a <= (k == 0) ? 3'h5 : 3'h2;
      pwr_n <= (k != 1);
      guard <= (k != 2);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (150) @(posedge clk);
      check("starts", 36'(starts), 36'(s0));
      unit_a <= 3'h2;
      pwr_n <= 1'b1;
      guard <= 1'b1;
      repeat (5) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      tcnt = tcnt + 1;
      if (tcnt == 20000)
      begin
         failures++;
         give_verdict;
      end
      if (rst_n && pb && !busy_n)
      begin
         tb0 = cyc;
         r = '{default: '0};
         starts <= starts + 1;
      end
      if (rst_n)
      begin
         if (!busy_n) r[0] = r[0] + 1;
         if (prd && !rd_n)
         begin
            r[1] = 36'(cyc - tb0);
            r[7] = rw;
            r[8] = 36'(la);
         end
         if (!rd_n) r[2] = r[2] + 1;
         if (pcd && !cd_n) r[3] = 36'(cyc - tb0);
         if (!cd_n) r[4] = r[4] + 1;
         if (!poe && oe) r[5] = 36'(cyc - tb0);
         if (oe) r[6] = r[6] + 1;
         if (cen != 4'h0)
         begin
            r[9] = cw;
            r[10] = 36'(cen);
         end
         if (!pb && busy_n) post = 1;
         else if (post > 0) post = post + 1;
         if (post == 20)
         begin
            post = 0;
            results <= results + 1;
            if (q.size() == 0) check("note", 36'h1, 36'h0);
            else
            begin
               e = q.pop_front();
               for (int k = 0; k < 11; k++)
                  if (e.m[k]) check(nm[k], r[k], e.f[k]);
            end
         end
      end
      pb = busy_n;
      prd = rd_n;
      pcd = cd_n;
      poe = oe;
   end
   initial
   begin
      logic [3:0] m;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      check("idle", 36'({oe, cd_n, rd_n, busy_n}), 36'h7);
      for (int i = 0; i < 7; i++)
         run_cyc(modes[i][3], modes[i][2], modes[i][1], modes[i][0]);
      for (int i = 0; i < 8; i++)
      begin
         m = 4'($random(seed));
         run_cyc(m[3], m[2], m[1], m[0]);
      end
      for (int k = 0; k < 3; k++)
         refuse(k);
      run_cyc(1'b0, 1'b1, 1'b1, 1'b0);
      give_verdict;
   end
endmodule
